/* shared/serirq_pkg.sv */
// Purpose: Shared constants and types for the serial interrupt line agent and host ends.
// Assumes: One clock for both ends; the line is sampled and driven on the rising edge.
// Notes:   Frame numbers run 1..FRAME_COUNT; frame 1 carries nothing.
`default_nettype none

package serirq_pkg;

    // Data frames per cycle and the width of a frame index.
    localparam int unsigned FRAME_W = 5;
    localparam logic [4:0] FRAME_COUNT = 5'h10;
    localparam logic [4:0] FIRST_OWNED_FRAME = 5'h02;

    // Stop Frame low widths, in clocks, that select the next cycle's mode.
    localparam logic [3:0] STOP_QUIET_LOW = 4'h2;
    localparam logic [3:0] STOP_CONT_LOW = 4'h3;

    // Host hold of the Start Frame after the first low clock, in clocks.
    localparam logic [3:0] START_HOLD_MIN = 4'h3;
    localparam logic [3:0] START_HOLD_MAX = 4'h7;

    // Reset values.
    localparam logic RESET_QUIET = 1'b0;
    localparam logic [15:0] RESET_LEVELS = 16'hffff;

    // The three clocks of every data frame, in order.
    typedef enum logic [1:0] {
        PH_SAMPLE,
        PH_RECOVER,
        PH_TURN
    } phase_t;

endpackage

`default_nettype wire

/* shared/serirq_if.sv */
// Purpose: Carrier for the shared open serial interrupt line between host and agent.
// Assumes: The line is pulled high when nobody drives it low.
// Notes:   Output enables are active low; a driven high and a driven low resolve to low.
`timescale 1ns/1ps
`default_nettype none

interface serirq_if;
    logic host_o;
    logic host_oe_n;
    logic agent_o;
    logic agent_oe_n;
    logic line;

    // Pulled-up wire: low only while some enabled driver sends low.
    assign line = (host_oe_n | host_o) & (agent_oe_n | agent_o);

    modport host (
        output host_o,
        output host_oe_n,
        input  line
    );

    modport agent (
        output agent_o,
        output agent_oe_n,
        input  line
    );
endinterface // serirq_if

`default_nettype wire

/* hw/serirq_agent.sv */
// Purpose: Agent end of the serial interrupt line; reports fifteen interrupt levels, or fourteen
//          and the system management interrupt, in fixed frames of each cycle.
// Assumes: The line is produced by same-clock logic and is read without a synchroniser;
//          interrupt inputs are asynchronous and are synchronised here.
// Notes:   Frame 3 carries the system management interrupt when smi_on_frame3 is high.
//
// Contract
// RULE1 - Quiet idle start: one low clock, then release
// RULE2 - Never start a frame while a cycle runs
// RULE3 - Host stretches start low, drives high, releases
// RULE4 - Level change in quiet mode triggers a start
// RULE5 - Continuous mode: only the host starts cycles
// RULE6 - Mode changes only at Stop; reset is continuous
// RULE7 - Stop width two quiet, three continuous
// RULE8 - Next start two clocks after stop rise
// RULE9 - Count three-clock frames from start rising edge
// RULE10 - Sample phase: drive low only for low level
// RULE11 - Recovery: drive high only after own low
// RULE12 - Turn-around phase always releases the line
// RULE13 - Report regardless of who started the cycle
// RULE14 - Frame n sample is clock 3n-1
// RULE15 - Frame 3 carries smi or irq2; frame 14 irq13
// RULE16 - Only the host issues the Stop Frame
// RULE17 - Drive and sample on rising clock edge
// RULE18 - Release line during reset; return to continuous
// RULE19 - Synchronise inputs, capture before the sample phase
`timescale 1ns/1ps
`default_nettype none

module serirq_agent (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [15:1] irq_in,
    input  wire logic        system_mgmt_irq_n,
    input  wire logic        smi_on_frame3,
    output logic             quiet_mode,
    output logic             cycle_active,
    output logic             stop_width_err,
    serirq_if.agent          bus
);

    typedef enum logic [2:0] {
        A_IDLE,
        A_START,
        A_WAIT_RISE,
        A_FRAMES,
        A_STOP_WAIT,
        A_GAP
    } agent_state_t;

    agent_state_t          state_r;
    serirq_pkg::phase_t    phase_r;
    serirq_pkg::phase_t    phase_nxt;
    logic [4:0]            frame_r;
    logic [4:0]            frame_nxt;
    logic [3:0]            low_cnt_r;
    logic                  quiet_r;
    logic                  o_r;
    logic                  oe_n_r;
    logic                  err_r;
    logic [15:1]           irq_meta_r;
    logic [15:1]           irq_sync_r;
    logic                  smi_meta_r;
    logic                  smi_sync_r;
    logic [16:2]           slot_lvl;
    logic [16:2]           sent_r;
    logic                  pending;
    logic                  owns_nxt;
    logic                  start_go;
    logic                  in_frames;

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_meta_r <= 15'h7fff;
            irq_sync_r <= 15'h7fff;
            smi_meta_r <= 1'b1;
            smi_sync_r <= 1'b1;
        end else begin
            irq_meta_r <= irq_in; // RULE19
            irq_sync_r <= irq_meta_r; // RULE19
            smi_meta_r <= system_mgmt_irq_n; // RULE19
            smi_sync_r <= smi_meta_r; // RULE19
        end
    end

    // Level carried by each owned frame: frame n reports interrupt n-1, except frame 3, which reports smi when smi_on_frame3 is high.
    always_comb begin
        slot_lvl[16:4] = irq_sync_r[15:3];
        slot_lvl[3] = smi_on_frame3 ? smi_sync_r : irq_sync_r[2]; // RULE15
        slot_lvl[2] = irq_sync_r[1];
    end

    // A level differs from what was last delivered to the host.
    assign pending = |(slot_lvl ^ sent_r); // RULE4

    // Starting is legal only on an idle line in quiet mode, after the stop gap.
    assign start_go = ((state_r == A_IDLE) || (state_r == A_GAP)) && bus.line
                      && quiet_r && pending; // RULE1 RULE2 RULE5 RULE8

    assign in_frames = (state_r == A_FRAMES);

    // Phase and frame of the clock that follows the current edge.
    always_comb begin
        phase_nxt = phase_r;
        frame_nxt = frame_r;
        case (phase_r)
            serirq_pkg::PH_SAMPLE: begin
                phase_nxt = serirq_pkg::PH_RECOVER; // RULE9
            end
            serirq_pkg::PH_RECOVER: begin
                phase_nxt = serirq_pkg::PH_TURN; // RULE9
            end
            default: begin
                phase_nxt = serirq_pkg::PH_SAMPLE; // RULE14
                frame_nxt = frame_r + 5'h01; // RULE14
            end
        endcase
    end

    assign owns_nxt = (frame_nxt >= serirq_pkg::FIRST_OWNED_FRAME)
                      && (frame_nxt <= serirq_pkg::FRAME_COUNT);

    // Cycle tracking, shared by host-started and self-started cycles.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= A_IDLE;
            phase_r <= serirq_pkg::PH_TURN;
            frame_r <= 5'h00;
            low_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                A_IDLE: begin
                    if (!bus.line) begin
                        state_r <= A_WAIT_RISE; // RULE13
                    end else if (start_go) begin
                        state_r <= A_START; // RULE4
                    end
                end
                A_START: begin
                    state_r <= A_WAIT_RISE; // RULE1
                end
                A_WAIT_RISE: begin
                    // The host holds the line low and then drives it high once.
                    if (bus.line) begin
                        state_r <= A_FRAMES; // RULE3 RULE9
                        phase_r <= serirq_pkg::PH_TURN; // RULE14
                        frame_r <= 5'h00; // RULE14
                    end
                end
                A_FRAMES: begin
                    phase_r <= phase_nxt;
                    frame_r <= frame_nxt;
                    if ((phase_r == serirq_pkg::PH_TURN)
                        && (frame_r == serirq_pkg::FRAME_COUNT)) begin
                        state_r <= A_STOP_WAIT; // RULE16
                        low_cnt_r <= 4'h0;
                    end
                end
                A_STOP_WAIT: begin
                    if (!bus.line) begin
                        if (low_cnt_r != 4'hf) begin
                            low_cnt_r <= low_cnt_r + 4'h1; // RULE7
                        end
                    end else if (low_cnt_r != 4'h0) begin
                        state_r <= A_GAP; // RULE8
                    end
                end
                default: begin
                    if (!bus.line) begin
                        state_r <= A_WAIT_RISE; // RULE13
                    end else if (start_go) begin
                        state_r <= A_START; // RULE8
                    end else begin
                        state_r <= A_IDLE;
                    end
                end
            endcase
        end
    end

    // Mode is taken from the Stop Frame width only; widths other than two or three keep the mode.
    always_ff @(posedge clock) begin
        if (srst) begin
            quiet_r <= serirq_pkg::RESET_QUIET; // RULE6 RULE18
            err_r <= 1'b0;
        end else begin
            err_r <= 1'b0;
            if ((state_r == A_STOP_WAIT) && bus.line && (low_cnt_r != 4'h0)) begin
                if (low_cnt_r == serirq_pkg::STOP_QUIET_LOW) begin
                    quiet_r <= 1'b1; // RULE6 RULE7
                end else if (low_cnt_r == serirq_pkg::STOP_CONT_LOW) begin
                    quiet_r <= 1'b0; // RULE6 RULE7
                end else begin
                    err_r <= 1'b1;
                end
            end
        end
    end

    // Line drive, registered so that each phase sees one stable value per clock.
    always_ff @(posedge clock) begin
        if (srst) begin
            o_r <= 1'b1; // RULE18
            oe_n_r <= 1'b1; // RULE18
        end else if (start_go) begin
            o_r <= 1'b0; // RULE1 RULE17
            oe_n_r <= 1'b0; // RULE1
        end else if (in_frames && (phase_nxt == serirq_pkg::PH_SAMPLE) && owns_nxt
                     && !slot_lvl[frame_nxt]) begin
            o_r <= 1'b0; // RULE10 RULE13
            oe_n_r <= 1'b0; // RULE10
        end else if (in_frames && (phase_nxt == serirq_pkg::PH_RECOVER)
                     && !oe_n_r && !o_r) begin
            o_r <= 1'b1; // RULE11
            oe_n_r <= 1'b0; // RULE11
        end else begin
            // Released; the start pulse is never followed by a high drive.
            o_r <= 1'b1; // RULE12 RULE1
            oe_n_r <= 1'b1; // RULE12
        end
    end

    // Record what each frame delivered so that only real changes request a start.
    always_ff @(posedge clock) begin
        if (srst) begin
            sent_r <= serirq_pkg::RESET_LEVELS[15:1];
        end else if (in_frames && (phase_nxt == serirq_pkg::PH_SAMPLE) && owns_nxt) begin
            sent_r[frame_nxt] <= slot_lvl[frame_nxt]; // RULE19 RULE4
        end
    end

    assign quiet_mode = quiet_r;
    assign cycle_active = (state_r == A_START) || (state_r == A_WAIT_RISE)
                          || (state_r == A_FRAMES) || (state_r == A_STOP_WAIT);
    assign stop_width_err = err_r;
    assign bus.agent_o = o_r;
    assign bus.agent_oe_n = oe_n_r;

endmodule // serirq_agent

`default_nettype wire

/* hw/serirq_host.sv */
// Purpose: Host end of the serial interrupt line; runs cycles and collects frame levels.
// Assumes: Same clock as the agent; the line is read directly on each rising edge.
// Notes:   start_hold below the minimum is raised to the minimum.
`timescale 1ns/1ps
`default_nettype none

module serirq_host (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        start_req,
    input  wire logic        next_quiet,
    input  wire logic [2:0]  start_hold,
    output logic [16:1]      irq_levels,
    output logic             levels_valid,
    output logic             quiet_mode,
    output logic             busy,
    serirq_if.host           bus
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_START_LOW,
        H_START_HIGH,
        H_FRAMES,
        H_STOP_LOW,
        H_STOP_HIGH,
        H_GAP
    } host_state_t;

    host_state_t           state_r;
    host_state_t           state_nxt;
    serirq_pkg::phase_t    phase_r;
    logic [4:0]            frame_r;
    logic [3:0]            cnt_r;
    logic [3:0]            hold_ext;
    logic [3:0]            hold_eff;
    logic                  quiet_r;
    logic                  mode_pend_r;
    logic                  o_r;
    logic                  oe_n_r;
    logic [16:1]           lvl_r;
    logic                  valid_r;
    logic                  agent_start;
    logic                  last_frame;

    assign hold_ext = {1'b0, start_hold};
    assign hold_eff = (hold_ext < serirq_pkg::START_HOLD_MIN) ? serirq_pkg::START_HOLD_MIN
                      : hold_ext;
    // An agent may only open a cycle while the mode is quiet.
    assign agent_start = (state_r == H_IDLE) && !bus.line && quiet_r;
    assign last_frame = (phase_r == serirq_pkg::PH_TURN)
                        && (frame_r == serirq_pkg::FRAME_COUNT);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            H_IDLE: begin
                if (agent_start || start_req) begin
                    state_nxt = H_START_LOW;
                end
            end
            H_START_LOW: begin
                if (cnt_r == 4'h1) begin
                    state_nxt = H_START_HIGH;
                end
            end
            H_START_HIGH: state_nxt = H_FRAMES;
            H_FRAMES: begin
                if (last_frame) begin
                    state_nxt = H_STOP_LOW;
                end
            end
            H_STOP_LOW: begin
                if (cnt_r == 4'h1) begin
                    state_nxt = H_STOP_HIGH;
                end
            end
            H_STOP_HIGH: state_nxt = H_GAP;
            default: state_nxt = start_req ? H_START_LOW : H_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= H_IDLE;
            cnt_r <= 4'h0;
            phase_r <= serirq_pkg::PH_TURN;
            frame_r <= 5'h00;
            mode_pend_r <= serirq_pkg::RESET_QUIET;
        end else begin
            state_r <= state_nxt;
            if ((state_r == H_IDLE) && agent_start) begin
                cnt_r <= hold_eff; // RULE3
            end else if ((state_r == H_IDLE || state_r == H_GAP) && start_req) begin
                cnt_r <= hold_eff + 4'h1; // RULE5
            end else if (state_r == H_START_LOW || state_r == H_STOP_LOW) begin
                cnt_r <= cnt_r - 4'h1;
            end else if ((state_r == H_FRAMES) && last_frame) begin
                cnt_r <= next_quiet ? serirq_pkg::STOP_QUIET_LOW
                         : serirq_pkg::STOP_CONT_LOW; // RULE7 RULE16
                mode_pend_r <= next_quiet;
            end
            if (state_r == H_START_HIGH) begin
                phase_r <= serirq_pkg::PH_TURN; // RULE9
                frame_r <= 5'h00;
            end else if (state_r == H_FRAMES) begin
                case (phase_r)
                    serirq_pkg::PH_SAMPLE: phase_r <= serirq_pkg::PH_RECOVER;
                    serirq_pkg::PH_RECOVER: phase_r <= serirq_pkg::PH_TURN;
                    default: begin
                        phase_r <= serirq_pkg::PH_SAMPLE; // RULE14
                        frame_r <= frame_r + 5'h01;
                    end
                endcase
            end
        end
    end

    // Drive follows the state of the coming clock: low phases, one high clock, release.
    always_ff @(posedge clock) begin
        if (srst) begin
            o_r <= 1'b1; // RULE18
            oe_n_r <= 1'b1; // RULE18
        end else begin
            o_r <= (state_nxt == H_START_HIGH) || (state_nxt == H_STOP_HIGH); // RULE3 RULE17
            oe_n_r <= !((state_nxt == H_START_LOW) || (state_nxt == H_STOP_LOW)
                        || (state_nxt == H_START_HIGH) || (state_nxt == H_STOP_HIGH));
        end
    end

    // Levels are sampled at the end of each sample clock; mode switches at the stop.
    always_ff @(posedge clock) begin
        if (srst) begin
            lvl_r <= serirq_pkg::RESET_LEVELS;
            valid_r <= 1'b0;
            quiet_r <= serirq_pkg::RESET_QUIET; // RULE6
        end else begin
            valid_r <= 1'b0;
            if ((state_r == H_FRAMES) && (phase_r == serirq_pkg::PH_SAMPLE)) begin
                lvl_r[frame_r] <= bus.line; // RULE14
            end
            if (state_r == H_STOP_HIGH) begin
                quiet_r <= mode_pend_r; // RULE6 RULE8
                valid_r <= 1'b1;
            end
        end
    end

    assign irq_levels = lvl_r;
    assign levels_valid = valid_r;
    assign quiet_mode = quiet_r;
    assign busy = (state_r != H_IDLE);
    assign bus.host_o = o_r;
    assign bus.host_oe_n = oe_n_r;

endmodule // serirq_host

`default_nettype wire

/* verification/serirq_checker.sv */
// Purpose: Concurrent checks on the shared serial interrupt line.
// Assumes: One clock; frame position is rebuilt here from the wire alone.
// Notes:   Position 0 is the high clock that ends a Start Frame.
`timescale 1ns/1ps
`default_nettype none

module serirq_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic host_o,
    input wire logic host_oe_n,
    input wire logic agent_o,
    input wire logic agent_oe_n,
    input wire logic line
);
    logic [3:0] low_run_r;
    logic [5:0] pos_r;
    logic [1:0] gap_r;
    logic       quiet_r;
    logic       agent_low;
    logic       agent_high;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    assign agent_low  = !agent_oe_n && !agent_o;
    assign agent_high = !agent_oe_n && agent_o;

    always_ff @(posedge clock) begin
        if (srst || line)
            low_run_r <= 4'h0;
        else if (low_run_r != 4'hf)
            low_run_r <= low_run_r + 4'h1;
    end

    // A low run of four or more is a Start Frame; its rising edge restarts the count.
    always_ff @(posedge clock) begin
        if (srst)
            pos_r <= 6'h3f;
        else if (line && low_run_r >= 4'h4)
            pos_r <= 6'h01;
        else if (pos_r != 6'h3f)
            pos_r <= pos_r + 6'h01;
    end

    // Gap counts clocks since the Stop Frame's high clock, so early starts are seen.
    always_ff @(posedge clock) begin
        if (srst || !line)
            gap_r <= 2'h0;
        else if (low_run_r == 4'h2 || low_run_r == 4'h3)
            gap_r <= 2'h1;
        else if (gap_r == 2'h1 || gap_r == 2'h2)
            gap_r <= gap_r + 2'h1;
    end

    always_ff @(posedge clock) begin
        if (srst)
            quiet_r <= 1'b0;
        else if (line && low_run_r == 4'h2)
            quiet_r <= 1'b1;
        else if (line && low_run_r == 4'h3)
            quiet_r <= 1'b0;
    end

    a_reset_release: assert property (
        $past(srst) |-> host_oe_n && agent_oe_n) else $error("line driven after reset");
    a_high_after_low: assert property (
        agent_high |-> $past(agent_low)) else $error("agent high without own low");
    a_low_one_clock: assert property (
        agent_low |=> !agent_low) else $error("agent low longer than one clock");
    a_turn_release: assert property (
        agent_high |=> agent_oe_n) else $error("agent kept line after recovery");
    a_start_idle: assert property (
        agent_low && pos_r > 6'h31 |-> quiet_r && gap_r >= 2'h2)
        else $error("agent start outside quiet idle");
    a_sample_slot: assert property (
        agent_low && pos_r <= 6'h31 |-> pos_r % 6'h03 == 6'h02 && pos_r >= 6'h05)
        else $error("agent low outside a sample clock");
    a_recover_slot: assert property (
        agent_high |-> pos_r % 6'h03 == 6'h00 && pos_r >= 6'h06 && pos_r <= 6'h30)
        else $error("agent high outside a recovery clock");
    a_host_release: assert property (
        !host_oe_n && host_o |=> host_oe_n) else $error("host high longer than one clock");
    a_start_width: assert property (
        line && low_run_r >= 4'h4 |-> low_run_r <= 4'h8) else $error("start pulse too long");
    a_stop_width: assert property (
        line && low_run_r != 4'h0 && low_run_r < 4'h4 && pos_r > 6'h31 |-> low_run_r >= 4'h2)
        else $error("stop pulse too short");
endmodule // serirq_checker

`default_nettype wire

/* verification/testbench.sv */
// Purpose: Self-checking bench for the host and agent ends on one serial interrupt line.
// Assumes: 250 MHz clock; inputs change on the falling edge.
// Notes:   Low runs are measured on the wire, so neither end grades its own widths.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clock = 1'b0;
    logic        srst;
    logic [15:1] irq_in;
    logic        system_mgmt_irq_n;
    logic        smi_on_frame3;
    logic        start_req;
    logic        next_quiet;
    logic [2:0]  start_hold;
    logic [16:1] irq_levels;
    logic        levels_valid;
    logic        host_quiet;
    logic        agent_quiet;
    logic        busy;
    logic        agent_active;
    logic        stop_err;
    logic        stop_err_seen = 1'b0;
    logic [4:0]  run_cnt = 5'h00;
    logic [4:0]  start_run = 5'h00;
    logic [4:0]  stop_run = 5'h00;
    int          error_cnt = 0;
    int          checked = 0;

    serirq_if bus ();

    serirq_agent u_serirq_agent (
        .clock             (clock),
        .srst              (srst),
        .irq_in            (irq_in),
        .system_mgmt_irq_n (system_mgmt_irq_n),
        .smi_on_frame3     (smi_on_frame3),
        .quiet_mode        (agent_quiet),
        .cycle_active      (agent_active),
        .stop_width_err    (stop_err),
        .bus               (bus)
    );

    serirq_host u_serirq_host (
        .clock        (clock),
        .srst         (srst),
        .start_req    (start_req),
        .next_quiet   (next_quiet),
        .start_hold   (start_hold),
        .irq_levels   (irq_levels),
        .levels_valid (levels_valid),
        .quiet_mode   (host_quiet),
        .busy         (busy),
        .bus          (bus)
    );

    serirq_checker chk_link (
        .clock      (clock),
        .srst       (srst),
        .host_o     (bus.host_o),
        .host_oe_n  (bus.host_oe_n),
        .agent_o    (bus.agent_o),
        .agent_oe_n (bus.agent_oe_n),
        .line       (bus.line)
    );

    always #2 clock = ~clock;

    always @(posedge clock) begin
        if (bus.line !== 1'b1) begin
            run_cnt <= run_cnt + 5'h01;
        end else begin
            if (run_cnt >= 5'h04)
                start_run <= run_cnt;
            else if (run_cnt >= 5'h02)
                stop_run <= run_cnt;
            run_cnt <= 5'h00;
        end
    end

    // Every stop width on this link is legal, so the agent's width error must never pulse.
    always @(posedge clock) begin
        if (stop_err === 1'b1)
            stop_err_seen <= 1'b1;
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_for(input logic want_valid);
        int i;
        for (i = 0; i < 400 && (want_valid ? levels_valid : busy) !== 1'b1; i++)
            @(negedge clock);
        if (i == 400) begin
            error_cnt++;
            $display("wrong value handshake expected 1 seen timeout");
            give_verdict();
        end
    endtask

    // Bit n of the result is frame n; frame 1 is never driven and reads high.
    function automatic logic [16:0] exp_lv(input logic [15:1] irqs, input logic smi_n,
                                           input logic sel);
        logic [16:0] e;
        e = {irqs, 1'b1, 1'b0};
        if (sel)
            e[3] = smi_n;
        return e;
    endfunction

    task automatic no_start(input logic [15:1] irqs);
        int lows;
        lows = 0;
        irq_in = irqs;
        repeat (80) begin
            @(negedge clock);
            if (bus.line !== 1'b1)
                lows++;
        end
        chk("idle lows", 17'h0, 17'(lows));
    endtask

    // One pause first: busy already stands in the host's gap state, so a request made there would be dropped.
    task automatic host_cycle(input logic q, input logic [2:0] hold, input logic [15:1] irqs,
                              input logic smi_n, input logic sel, input logic own);
        @(negedge clock);
        next_quiet = q;
        start_hold = hold;
        irq_in = irqs;
        system_mgmt_irq_n = smi_n;
        smi_on_frame3 = sel;
        start_req = own;
        if (own) begin
            wait_for(1'b0);
            start_req = 1'b0;
        end
        wait_for(1'b1);
        chk("levels", exp_lv(irqs, smi_n, sel), {irq_levels, 1'b0});
        chk("start width", (hold < 3'h3) ? 17'h4 : 17'(hold) + 17'h1, 17'(start_run));
        chk("stop width", q ? 17'h2 : 17'h3, 17'(stop_run));
        chk("host mode", 17'(q), 17'(host_quiet));
        chk("agent mode", 17'(q), 17'(agent_quiet));
        chk("agent active", 17'h0, 17'(agent_active));
    endtask

    initial begin
        srst = 1'b1;
        irq_in = 15'h7fff;
        system_mgmt_irq_n = 1'b1;
        smi_on_frame3 = 1'b0;
        start_req = 1'b0;
        next_quiet = 1'b0;
        start_hold = 3'h0;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        chk("line after reset", 17'h1, 17'(bus.line));
        chk("mode after reset", 17'h0, 17'({host_quiet, agent_quiet}));
        no_start(15'h5a5a);
        host_cycle(1'b1, 3'h0, 15'h5a5a, 1'b1, 1'b0, 1'b1);
        host_cycle(1'b1, 3'h7, 15'h0ff0, 1'b0, 1'b1, 1'b1);
        host_cycle(1'b0, 3'h3, 15'h0fe0, 1'b0, 1'b1, 1'b0);
        no_start(15'h7fff);
        host_cycle(1'b0, 3'h5, 15'h7ffe, 1'b1, 1'b0, 1'b1);
        // A reset in mid-cycle must free the wire; the host must leave its gap state first,
        // since busy already stands there and the request would be dropped.
        @(negedge clock);
        start_req = 1'b1;
        wait_for(1'b0);
        start_req = 1'b0;
        repeat (20) @(negedge clock);
        chk("agent active", 17'h1, 17'(agent_active));
        srst = 1'b1;
        repeat (3) @(negedge clock);
        chk("line in reset", 17'h1, 17'(bus.line));
        srst = 1'b0;
        host_cycle(1'b0, 3'h4, 15'h1234, 1'b1, 1'b0, 1'b1);
        chk("stop width error", 17'h0, 17'(stop_err_seen));
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
